// ---- hw/amp_ctrl_pkg.sv ----
// amp_ctrl_pkg: register map, field positions and codes for the clock detect, hi-z and volume slice
// assumes: 8-bit register addresses and 8-bit register data
package amp_ctrl_pkg;

  // register offsets
  localparam logic [7:0] ADDR_CLOCK_DETECT_FLAGS = 8'h39;
  localparam logic [7:0] ADDR_CHANNEL_HIZ_FORCE  = 8'h40;
  localparam logic [7:0] ADDR_SHARED_VOLUME      = 8'h4C;

  // reset values
  localparam logic [7:0] RST_CLOCK_DETECT_FLAGS  = 8'h00;
  localparam logic [7:0] RST_CHANNEL_HIZ_FORCE   = 8'h01;
  localparam logic [7:0] RST_SHARED_VOLUME       = 8'h30;

  // clock_detect_flags bit positions
  localparam int FLAG_BCK_RATE_FAULT = 5;
  localparam int FLAG_PLL_OVERRATE   = 4;
  localparam int FLAG_PLL_LOCKED     = 3;
  localparam int FLAG_BCK_MISSING    = 2;
  localparam int FLAG_BCK_VALID      = 1;
  localparam int FLAG_FS_ERROR       = 0;
  localparam int FLAG_STATUS_WIDTH   = 6;

  // channel_hiz_force bit positions
  localparam int HIZ_LEFT_BIT  = 4;
  localparam int HIZ_RIGHT_BIT = 3;

  // volume codes, gain counted in half-dB units
  localparam logic [7:0] VOLUME_UNITY     = 8'h30;
  localparam logic [7:0] VOLUME_MUTE      = 8'hFF;
  localparam logic [7:0] VOLUME_STEP      = 8'h01;
  localparam logic [8:0] GAIN_TOP_HALF_DB = 9'h030;

  // bit clock ratio span, in bit clocks per frame
  localparam logic [9:0] BCK_RATIO_MIN = 10'h020;
  localparam logic [9:0] BCK_RATIO_MAX = 10'h200;

  // sample rate detection
  localparam logic [3:0] FS_MODE_AUTO  = 4'h0;
  localparam logic [3:0] FS_CODE_ERROR = 4'h0;

  // crossing vector layout: five flags, four rate bits, one frame toggle
  localparam int XING_WIDTH = 10;

endpackage

// ---- hw/cdc_sync.sv ----
// cdc_sync: two flip-flop level synchroniser, one per bit
// assumes: each bit is a quasi-static level from a foreign clock domain
`timescale 1ns/1ps
`default_nettype none
module cdc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,    // destination clock
  input  wire logic             resetn, // synchronous reset, active low
  input  wire logic [WIDTH-1:0] d,      // foreign-domain levels
  output logic      [WIDTH-1:0] q       // synchronised levels
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_s;

  sync_s state;
  sync_s next_state;

  always_comb begin
    next_state        = state;
    next_state.stage1 = d;
    next_state.stage2 = state.stage1;
    if (!resetn) begin
      next_state = '0;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign q = state.stage2;

endmodule
`default_nettype wire

// ---- hw/clock_detect_hiz_volume_regs.sv ----
// clock_detect_hiz_volume_regs: clock detect status, per-channel hi-z force and shared volume
// assumes: the two-wire engine presents one-cycle read/write strobes on clk; detector inputs are
// produced by logic running on link_clk
//
// Behaviour
// - Status bit 5 shows the bit clock running outside its supported rate.
// - Status bit 4 shows a PLL overrate.
// - Status bit 3 shows PLL lock and reads unlocked whenever the PLL is disabled.
// - Status bit 2 shows that the bit clock is absent.
// - Status bit 1 shows bit clock valid only when the ratio is stable and within 32 to 512 per frame.
// - Status bit 0 shows an invalid rate in auto mode and a configured-versus-detected mismatch otherwise.
// - The rate error flag is raised even when rate errors are set to be ignored.
// - Force bit 4 floats the left output; clearing it hands the channel back to device state control.
// - Force bit 3 floats the right output; clearing it hands the channel back to device state control.
// - A floated channel leaves that state only when its force bit is written to zero, parallel bridged mono mode is set or resetn is driven low.
// - The force bits have no effect in parallel bridged mono mode.
// - One 8-bit volume code serves both channels.
// - Code zero is +24 dB, each code lowers gain by 0.5 dB, 0x30 is unity and 0xFE is -103 dB.
// - Code 0xFF mutes both channels.
// - The applied volume walks to a new code by one half-dB step per sample period.
`timescale 1ns/1ps
`default_nettype none
module clock_detect_hiz_volume_regs
  import amp_ctrl_pkg::*;
(
  input  wire logic       clk,                        // register clock
  input  wire logic       resetn,                     // synchronous reset, active low
  input  wire logic       link_clk,                   // audio bit clock domain
  input  wire logic       link_resetn,                // synchronous reset on link_clk, active low
  input  wire logic [7:0] reg_addr,                   // register address
  input  wire logic [7:0] reg_wdata,                  // write data
  input  wire logic       reg_write,                  // write strobe
  input  wire logic       reg_read,                   // read strobe
  output logic      [7:0] reg_rdata,                  // read data
  output logic            reg_rvalid,                 // read data valid pulse
  input  wire logic       bck_rate_fault,             // link: bit clock over or under rate
  input  wire logic       pll_overrate,               // link: pll overrate
  input  wire logic       pll_lock,                   // link: pll locked
  input  wire logic       bck_absent,                 // link: bit clock missing
  input  wire logic       bck_ratio_stable,           // link: ratio steady
  input  wire logic [9:0] bck_ratio,                  // link: bit clocks per frame
  input  wire logic [3:0] detected_fs,                // link: detected rate code
  input  wire logic       frame_strobe,               // link: one pulse per sample frame
  input  wire logic       pll_enable,                 // pll enabled
  input  wire logic [3:0] fs_mode,                    // rate mode, zero is auto
  input  wire logic [3:0] configured_fs,              // configured rate code
  input  wire logic       fs_error_ignore,            // ignore rate errors
  input  wire logic       parallel_bridged_mono_mode, // output stage bridged mono
  output logic            left_output_float,          // left channel forced hi-z
  output logic            right_output_float,         // right channel forced hi-z
  output logic      [7:0] left_volume_code,           // applied left volume code
  output logic      [7:0] right_volume_code,          // applied right volume code
  output logic      [8:0] gain_half_db,               // applied gain, signed half-dB
  output logic            left_mute,                  // left fully muted
  output logic            right_mute,                 // right fully muted
  output logic            fs_error_mute               // rate error reaction
);

  // link domain capture
  typedef struct packed {
    logic       rate_fault;
    logic       overrate;
    logic       lock;
    logic       absent;
    logic       bck_valid;
    logic [3:0] fs;
    logic       frame_toggle;
  } link_s;

  link_s link_state;
  link_s next_link_state;

  always_comb begin
    next_link_state            = link_state;
    next_link_state.rate_fault = bck_rate_fault;
    next_link_state.overrate   = pll_overrate;
    next_link_state.lock       = pll_lock;
    next_link_state.absent     = bck_absent;
    next_link_state.bck_valid  = bck_ratio_stable && (bck_ratio >= BCK_RATIO_MIN)
                                 && (bck_ratio <= BCK_RATIO_MAX);
    next_link_state.fs         = detected_fs;
    if (frame_strobe) begin
      next_link_state.frame_toggle = !link_state.frame_toggle;
    end
    if (!link_resetn) begin
      next_link_state = '0;
    end
  end

  always_ff @(posedge link_clk) begin
    link_state <= next_link_state;
  end

  // crossing into clk
  logic [XING_WIDTH-1:0] xing_sync;

  cdc_sync #(
    .WIDTH (XING_WIDTH)
  ) u_xing (
    .clk    (clk),
    .resetn (resetn),
    .d      (link_state),
    .q      (xing_sync)
  );

  link_s synced;
  assign synced = link_s'(xing_sync);

  // register clock state
  typedef struct packed {
    logic [1:0] flags_spare;
    logic [5:0] flags;
    logic [7:0] hiz_force;
    logic [7:0] volume;
    logic [7:0] applied;
    logic [8:0] gain;
    logic       lfloat;
    logic       rfloat;
    logic       lmute;
    logic       rmute;
    logic       fsmute;
    logic       toggle_seen;
    logic [3:0] fs_prev;
    logic [3:0] fs_held;
    logic [7:0] rdata;
    logic       rvalid;
  } regs_s;

  regs_s state;
  regs_s next_state;
  logic  sample_tick;
  logic  fs_error;

  assign sample_tick = synced.frame_toggle != state.toggle_seen;

  // rate code taken only once two samples agree, so a torn code never reaches the flag
  always_comb begin
    if (fs_mode == FS_MODE_AUTO) begin
      fs_error = state.fs_held == FS_CODE_ERROR;
    end else begin
      fs_error = state.fs_held != configured_fs;
    end
  end

  always_comb begin
    next_state             = state;
    next_state.toggle_seen = synced.frame_toggle;
    next_state.fs_prev     = synced.fs;
    if (synced.fs == state.fs_prev) begin
      next_state.fs_held = synced.fs;
    end

    next_state.flags[FLAG_BCK_RATE_FAULT] = synced.rate_fault;
    next_state.flags[FLAG_PLL_OVERRATE]   = synced.overrate;
    next_state.flags[FLAG_PLL_LOCKED]     = synced.lock && pll_enable;
    next_state.flags[FLAG_BCK_MISSING]    = synced.absent;
    next_state.flags[FLAG_BCK_VALID]      = synced.bck_valid;
    next_state.flags[FLAG_FS_ERROR]       = fs_error;
    next_state.fsmute                     = fs_error && !fs_error_ignore;

    // register writes
    if (reg_write) begin
      unique case (reg_addr)
        ADDR_CLOCK_DETECT_FLAGS: next_state.flags_spare = reg_wdata[7:FLAG_STATUS_WIDTH];
        ADDR_CHANNEL_HIZ_FORCE:  next_state.hiz_force   = reg_wdata;
        ADDR_SHARED_VOLUME:      next_state.volume      = reg_wdata;
        default: begin
        end
      endcase
    end

    // register reads, unmapped reads return zero
    next_state.rvalid = reg_read;
    if (reg_read) begin
      unique case (reg_addr)
        ADDR_CLOCK_DETECT_FLAGS: next_state.rdata = {state.flags_spare, state.flags};
        ADDR_CHANNEL_HIZ_FORCE:  next_state.rdata = state.hiz_force;
        ADDR_SHARED_VOLUME:      next_state.rdata = state.volume;
        default:                 next_state.rdata = '0;
      endcase
    end

    // hi-z force, ignored in bridged mono
    next_state.lfloat = next_state.hiz_force[HIZ_LEFT_BIT] && !parallel_bridged_mono_mode;
    next_state.rfloat = next_state.hiz_force[HIZ_RIGHT_BIT] && !parallel_bridged_mono_mode;

    // volume walks one code per sample period
    if (sample_tick) begin
      if (state.applied < state.volume) begin
        next_state.applied = state.applied + VOLUME_STEP;
      end else if (state.applied > state.volume) begin
        next_state.applied = state.applied - VOLUME_STEP;
      end
    end
    next_state.gain  = GAIN_TOP_HALF_DB - {1'b0, next_state.applied};
    next_state.lmute = next_state.applied == VOLUME_MUTE;
    next_state.rmute = next_state.applied == VOLUME_MUTE;

    if (!resetn) begin
      next_state             = '0;
      next_state.flags_spare = RST_CLOCK_DETECT_FLAGS[7:FLAG_STATUS_WIDTH];
      next_state.flags       = RST_CLOCK_DETECT_FLAGS[FLAG_STATUS_WIDTH-1:0];
      next_state.hiz_force   = RST_CHANNEL_HIZ_FORCE;
      next_state.volume      = RST_SHARED_VOLUME;
      next_state.applied     = RST_SHARED_VOLUME;
      next_state.gain        = GAIN_TOP_HALF_DB - {1'b0, RST_SHARED_VOLUME};
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign reg_rdata          = state.rdata;
  assign reg_rvalid         = state.rvalid;
  assign left_output_float  = state.lfloat;
  assign right_output_float = state.rfloat;
  assign left_volume_code   = state.applied;
  assign right_volume_code  = state.applied;
  assign gain_half_db       = state.gain;
  assign left_mute          = state.lmute;
  assign right_mute         = state.rmute;
  assign fs_error_mute      = state.fsmute;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_pll_disabled_unlocked: assert property (
    !pll_enable |=> !state.flags[FLAG_PLL_LOCKED])
    else $error("pll lock shown while pll disabled");

  a_flag_read_back: assert property (
    reg_read && reg_addr == ADDR_CLOCK_DETECT_FLAGS
    |=> reg_rvalid && reg_rdata[FLAG_STATUS_WIDTH-1:0] == $past(state.flags))
    else $error("status read does not return synchronised flags");

  a_fs_error_kept: assert property (
    fs_error_ignore && fs_error |=> state.flags[FLAG_FS_ERROR] && !fs_error_mute)
    else $error("rate error flag dropped or reacted while ignored");

  a_float_bridged_off: assert property (
    parallel_bridged_mono_mode |=> !left_output_float && !right_output_float)
    else $error("hi-z force acted in bridged mono");

  a_left_float_set: assert property (
    reg_write && reg_addr == ADDR_CHANNEL_HIZ_FORCE && reg_wdata[HIZ_LEFT_BIT]
    && !parallel_bridged_mono_mode |=> left_output_float)
    else $error("left channel not floated by its force bit");

  a_right_float_set: assert property (
    reg_write && reg_addr == ADDR_CHANNEL_HIZ_FORCE && reg_wdata[HIZ_RIGHT_BIT]
    && !parallel_bridged_mono_mode |=> right_output_float)
    else $error("right channel not floated by its force bit");

  a_float_exit_write: assert property (
    $fell(left_output_float) |->
    $past(parallel_bridged_mono_mode) || $past(reg_write && reg_addr == ADDR_CHANNEL_HIZ_FORCE))
    else $error("left float left without a clearing write");

  a_right_exit_write: assert property (
    $fell(right_output_float) |->
    $past(parallel_bridged_mono_mode) || $past(reg_write && reg_addr == ADDR_CHANNEL_HIZ_FORCE))
    else $error("right float left without a clearing write");

  a_left_float_held: assert property (
    left_output_float && !parallel_bridged_mono_mode
    && !(reg_write && reg_addr == ADDR_CHANNEL_HIZ_FORCE) |=> left_output_float)
    else $error("left float dropped without a clearing write");

  a_right_float_held: assert property (
    right_output_float && !parallel_bridged_mono_mode
    && !(reg_write && reg_addr == ADDR_CHANNEL_HIZ_FORCE) |=> right_output_float)
    else $error("right float dropped without a clearing write");

  a_unity_gain: assert property (
    left_volume_code == VOLUME_UNITY |-> gain_half_db == '0)
    else $error("unity code does not give zero gain");

  a_volume_one_step: assert property (
    left_volume_code != $past(left_volume_code) |->
    $past(sample_tick) && (left_volume_code == $past(left_volume_code) + VOLUME_STEP
    || left_volume_code == $past(left_volume_code) - VOLUME_STEP))
    else $error("volume moved without a tick or by more than one step");

  a_gain_and_mute: assert property (
    gain_half_db == GAIN_TOP_HALF_DB - {1'b0, left_volume_code}
    && left_mute == (right_volume_code == VOLUME_MUTE) && right_mute == left_mute)
    else $error("gain or mute does not match applied code");

  a_bck_valid_span: assert property (@(posedge link_clk) disable iff (!link_resetn)
    link_state.bck_valid |-> $past(bck_ratio_stable) && $past(bck_ratio) >= BCK_RATIO_MIN
    && $past(bck_ratio) <= BCK_RATIO_MAX)
    else $error("bit clock valid outside span");

  c_left_floated:  cover property ($rose(left_output_float));
  c_volume_target: cover property ($past(left_volume_code) != $past(state.volume)
                                   && left_volume_code == state.volume);
  c_muted:         cover property ($rose(left_mute));
  c_fs_error:      cover property ($rose(state.flags[FLAG_FS_ERROR]));

endmodule
`default_nettype wire

// ---- verification/link_source.sv ----
// link_source: link-side model that drives detector levels and one frame pulse per request
// assumes: frame_req is toggled in the register domain, at least a few register cycles apart
`timescale 1ns/1ps
`default_nettype none
module link_source (
  input  wire logic       link_clk,         // link clock, free running
  input  wire logic       link_resetn,      // link reset, active low
  input  wire logic [4:0] want_flags,       // fault, overrate, lock, absent, stable
  input  wire logic [9:0] want_ratio,       // bit clocks per frame
  input  wire logic [3:0] want_fs,          // detected rate code
  input  wire logic       frame_req,        // toggles once per frame wanted
  output logic            bck_rate_fault,   // rate out of span
  output logic            pll_overrate,     // pll overrate
  output logic            pll_lock,         // pll locked
  output logic            bck_absent,       // bit clock missing
  output logic            bck_ratio_stable, // ratio steady
  output logic      [9:0] bck_ratio,        // ratio level
  output logic      [3:0] detected_fs,      // rate code level
  output logic            frame_strobe      // one link cycle per frame
);
  logic seen_req;

  // levels change only on link edges, as a real detector would
  always_ff @(posedge link_clk) begin
    if (!link_resetn) begin
      {bck_rate_fault, pll_overrate, pll_lock, bck_absent, bck_ratio_stable} <= 5'h00;
      bck_ratio <= 10'h000;
      detected_fs <= 4'h0;
      frame_strobe <= 1'b0;
      seen_req <= frame_req;
    end else begin
      {bck_rate_fault, pll_overrate, pll_lock, bck_absent, bck_ratio_stable} <= want_flags;
      bck_ratio <= want_ratio;
      detected_fs <= want_fs;
      frame_strobe <= frame_req ^ seen_req;
      seen_req <= frame_req;
    end
  end
endmodule
`default_nettype wire

// ---- verification/test_clock_detect_hiz_volume_regs.sv ----
// test_clock_detect_hiz_volume_regs: self-checking bench for status, hi-z force and volume
// assumes: link_source stands at the link side; register access by one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`define chk(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_clock_detect_hiz_volume_regs
  import amp_ctrl_pkg::*;
;
  logic clk = 0, resetn = 0, link_clk = 0, frame_req = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic reg_write = 0, reg_read = 0, reg_rvalid;
  logic [4:0] want_flags = 0;
  logic [9:0] want_ratio = 0, bck_ratio;
  logic [3:0] want_fs = 0, detected_fs, fs_mode = 0, configured_fs = 0;
  logic pll_enable = 0, fs_error_ignore = 0, parallel_bridged_mono_mode = 0;
  logic bck_rate_fault, pll_overrate, pll_lock, bck_absent, bck_ratio_stable, frame_strobe;
  logic left_output_float, right_output_float, left_mute, right_mute, fs_error_mute;
  logic [7:0] left_volume_code, right_volume_code;
  logic [8:0] gain_half_db;
  int err_count = 0, total_checks = 0;

  always #25 clk = ~clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  link_source link_u (.link_clk(link_clk), .link_resetn(resetn), .want_flags(want_flags),
    .want_ratio(want_ratio), .want_fs(want_fs), .frame_req(frame_req), .bck_rate_fault(bck_rate_fault),
    .pll_overrate(pll_overrate), .pll_lock(pll_lock), .bck_absent(bck_absent),
    .bck_ratio_stable(bck_ratio_stable), .bck_ratio(bck_ratio), .detected_fs(detected_fs),
    .frame_strobe(frame_strobe));

  clock_detect_hiz_volume_regs dut_u (.clk(clk), .resetn(resetn), .link_clk(link_clk),
    .link_resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .bck_rate_fault(bck_rate_fault),
    .pll_overrate(pll_overrate), .pll_lock(pll_lock), .bck_absent(bck_absent),
    .bck_ratio_stable(bck_ratio_stable), .bck_ratio(bck_ratio), .detected_fs(detected_fs),
    .frame_strobe(frame_strobe), .pll_enable(pll_enable), .fs_mode(fs_mode), .configured_fs(configured_fs),
    .fs_error_ignore(fs_error_ignore), .parallel_bridged_mono_mode(parallel_bridged_mono_mode),
    .left_output_float(left_output_float), .right_output_float(right_output_float),
    .left_volume_code(left_volume_code), .right_volume_code(right_volume_code),
    .gain_half_db(gain_half_db), .left_mute(left_mute), .right_mute(right_mute),
    .fs_error_mute(fs_error_mute));

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge clk);
    #2;
    reg_write = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #2;
    reg_addr = a;
    reg_read = 1'b1;
    @(posedge clk);
    #2;
    reg_read = 1'b0;
    `chk(reg_rvalid, 1'b1)
    `chk(reg_rdata, e)
  endtask

  task automatic frame();
    frame_req = ~frame_req;
    repeat (12) @(posedge clk);
    #2;
  endtask

  function automatic logic [7:0] exp_flags();
    logic [7:0] e;
    e = 8'h00;
    e[5] = want_flags[4];
    e[4] = want_flags[3];
    e[3] = want_flags[2] & pll_enable;
    e[2] = want_flags[1];
    e[1] = want_flags[0] && want_ratio >= 10'h020 && want_ratio <= 10'h200;
    e[0] = (fs_mode == 4'h0) ? (want_fs == 4'h0) : (want_fs != configured_fs);
    return e;
  endfunction

  // one extra frame at the target checks that the applied code holds
  task automatic ramp_to(input logic [7:0] t);
    logic [7:0] c;
    logic done;
    wr(ADDR_SHARED_VOLUME, t);
    rd_chk(ADDR_SHARED_VOLUME, t);
    for (int n = 0; n < 300; n++) begin
      c = left_volume_code;
      done = (c === t);
      frame();
      if (c !== t) c = (c < t) ? c + 8'h01 : c - 8'h01;
      `chk(left_volume_code, c)
      `chk(right_volume_code, c)
      `chk(gain_half_db, 9'h030 - {1'b0, c})
      `chk({left_mute, right_mute}, {2{c == 8'hFF}})
      if (done) break;
    end
  endtask

  initial begin
    #2_000_000;
    err_count++;
    complete_run();
  end

  initial begin
    logic [7:0] d;
    logic [9:0] corner [4];
    logic [7:0] hz_d [6];
    logic hz_m [6];
    corner = '{10'h01F, 10'h020, 10'h200, 10'h201};
    hz_d = '{8'h18, 8'h18, 8'h10, 8'h08, 8'h08, 8'h00};
    hz_m = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    void'($urandom(23));
    repeat (20) @(posedge clk);
    #2;
    resetn = 1'b1;
    // detected rate is still 0000 in auto mode, so the rate error bit reads set
    rd_chk(ADDR_CLOCK_DETECT_FLAGS, RST_CLOCK_DETECT_FLAGS | exp_flags());
    rd_chk(ADDR_CHANNEL_HIZ_FORCE, RST_CHANNEL_HIZ_FORCE);
    rd_chk(ADDR_SHARED_VOLUME, RST_SHARED_VOLUME);
    rd_chk(8'h41, 8'h00);
    `chk({left_output_float, right_output_float, left_volume_code, gain_half_db}, {2'b00, 8'h30, 9'h000})
    wr(ADDR_CLOCK_DETECT_FLAGS, 8'hFF);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      #2;
      want_ratio = (i < 4) ? corner[i] : 10'($urandom_range(0, 1023));
      want_flags = 5'($urandom) | ((i < 4) ? 5'h01 : 5'h00);
      want_fs = 4'($urandom_range(0, 2));
      fs_mode = (i % 3 == 0) ? 4'h0 : 4'($urandom_range(1, 15));
      configured_fs = 4'($urandom_range(0, 2));
      pll_enable = 1'($urandom);
      fs_error_ignore = 1'($urandom);
      repeat (30) @(posedge clk);
      #2;
      rd_chk(ADDR_CLOCK_DETECT_FLAGS, exp_flags() | 8'hC0);
      `chk(fs_error_mute, exp_flags() & ~fs_error_ignore & 1'b1)
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      #2;
      parallel_bridged_mono_mode = hz_m[i];
      d = hz_d[i] | (8'($urandom) & 8'hE7);
      wr(ADDR_CHANNEL_HIZ_FORCE, d);
      @(posedge clk);
      #2;
      `chk(left_output_float, d[4] & ~hz_m[i])
      `chk(right_output_float, d[3] & ~hz_m[i])
      rd_chk(ADDR_CHANNEL_HIZ_FORCE, d);
    end
    ramp_to(8'h00);
    ramp_to(8'hFF);
    // mid-run reset from a muted, ramped state
    @(posedge clk);
    #2;
    resetn = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    resetn = 1'b1;
    @(posedge clk);
    #2;
    `chk({left_mute, right_mute, left_volume_code, gain_half_db}, {2'b00, RST_SHARED_VOLUME, 9'h000})
    rd_chk(ADDR_CHANNEL_HIZ_FORCE, RST_CHANNEL_HIZ_FORCE);
    ramp_to(8'($urandom));
    ramp_to(VOLUME_UNITY);
    complete_run();
  end
endmodule
`default_nettype wire
